// [src/hex_loader_consts.vh]
`ifndef HEX_LOADER_CONSTS_VH
`define HEX_LOADER_CONSTS_VH

// ----------------------------------------
// program memory map
// ----------------------------------------
`define FLASH_TOP_16K 16'h3FFF
`define FLASH_TOP_32K 16'h7FFF
`define BOOT_AREA_BASE 16'hF800
`define BOOT_AREA_TOP 16'hFFFF

// ----------------------------------------
// serial characters
// ----------------------------------------
`define CH_SYNC 8'h55
`define CH_COLON 8'h3A
`define CH_OK 8'h2E
`define CH_CSUM_ERR 8'h58
`define CH_PROG_ERR 8'h52

// ----------------------------------------
// records
// ----------------------------------------
`define REC_DATA 8'h00
`define REC_EOF 8'h01
`define REC_OSC 8'h02
`define REC_MAX_DATA 5'h10

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 10000000
`define BAUD_CNT_W 16
`define FIFO_DEPTH 8

`endif

// [src/byte_fifo.v]
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // fill side
  input wire i_valid,
  output wire o_ready,
  input wire [WIDTH-1:0] i_data,
  // drain side
  output wire o_valid,
  input wire i_ready,
  output reg [WIDTH-1:0] o_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  reg out_full;
  wire [AW:0] count;
  wire push;
  wire pop;
  wire load;

  assign count = wr_ptr - rd_ptr;
  assign o_ready = (count != DEPTH[AW:0]) || (DEPTH[AW:0] == {(AW+1){1'b0}});
  assign push = i_valid && o_ready;
  assign o_valid = out_full;
  assign pop = out_full && i_ready;
  // output register refills whenever it empties, keeping data registered
  assign load = (count != {(AW+1){1'b0}}) && (!out_full || pop);

  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      o_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        o_data <= mem[rd_ptr[AW-1:0]];
        rd_ptr <= rd_ptr + 1'b1;
        out_full <= 1'b1;
      end else if (pop) begin
        out_full <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [src/record_buffer.v]
`timescale 1ns/1ns
`default_nettype none
module record_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [WIDTH-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [WIDTH-1:0] o_rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// [src/hex_record_loader.v]
`timescale 1ns/1ns
`default_nettype none
`include "hex_loader_consts.vh"
module hex_record_loader #(
  parameter FLASH_32K = 1,
  parameter BW = `BAUD_CNT_W
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // serial pins
  input wire i_rxd,
  output reg o_txd,
  // fetch steering
  input wire i_external_fetch_select_pin,
  input wire [15:0] i_fetch_addr,
  output wire o_fetch_internal,
  output wire o_fetch_external,
  output wire o_fetch_boot,
  // flash programming port
  output reg o_prog_req,
  output reg [15:0] o_prog_addr,
  output reg [7:0] o_prog_data,
  input wire i_prog_done,
  input wire i_prog_ok,
  // status
  output wire o_baud_locked,
  output reg o_eof_seen
);
  // ----------------------------------------
  // fetch steering
  // ----------------------------------------
  wire [15:0] flash_top;
  wire ea_high;
  reg ea_s1;
  reg ea_s2;
  assign flash_top = (FLASH_32K != 0) ? `FLASH_TOP_32K : `FLASH_TOP_16K;
  assign ea_high = ea_s2;
  assign o_fetch_boot = (i_fetch_addr >= `BOOT_AREA_BASE);
  assign o_fetch_internal = ea_high && (i_fetch_addr <= flash_top) && !o_fetch_boot;
  // pin low forces all fetches below the boot area external
  assign o_fetch_external = !o_fetch_boot && (!ea_high || (i_fetch_addr > flash_top));

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg rx_s1;
  reg rx;
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_s1 <= 1'b1;
      rx <= 1'b1;
      ea_s1 <= 1'b1;
      ea_s2 <= 1'b1;
    end else begin
      rx_s1 <= i_rxd;
      rx <= rx_s1;
      ea_s1 <= i_external_fetch_select_pin;
      ea_s2 <= ea_s1;
    end
  end

  // ----------------------------------------
  // baud measurement and receiver
  // ----------------------------------------
  // U = 0x55: start bit low for one bit, then data bit0 high: low run = one bit
  localparam RX_IDLE = 2'h0;
  localparam RX_MEAS = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;
  reg [1:0] rx_state;
  reg locked;
  reg [BW-1:0] bit_cnt;
  reg [BW-1:0] rx_timer;
  reg [3:0] rx_bits;
  reg [7:0] rx_shift;
  reg rx_strobe;
  reg [7:0] rx_byte;
  assign o_baud_locked = locked;

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_state <= RX_IDLE;
      locked <= 1'b0;
      bit_cnt <= 16'h0000;
      rx_timer <= 16'h0000;
      rx_bits <= 4'h0;
      rx_shift <= 8'h00;
      rx_strobe <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_strobe <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_timer <= 16'h0001;
          if (!rx) begin
            rx_state <= locked ? RX_DATA : RX_MEAS;
            rx_bits <= 4'h0;
            rx_timer <= locked ? (bit_cnt + (bit_cnt >> 1)) : 16'h0001;
          end
        end
        RX_MEAS: begin
          if (rx) begin
            bit_cnt <= rx_timer;
            locked <= 1'b1;
            rx_state <= RX_STOP;
            rx_timer <= {rx_timer[BW-2:0], 1'b0} + (rx_timer >> 1) + rx_timer * 16'h0006;
          end else begin
            rx_timer <= rx_timer + 1'b1;
          end
        end
        RX_DATA: begin
          if (rx_timer == 16'h0000) begin
            rx_shift <= {rx, rx_shift[7:1]};
            rx_bits <= rx_bits + 1'b1;
            rx_timer <= bit_cnt - 1'b1;
            if (rx_bits == 4'h7) begin
              rx_state <= RX_STOP;
            end
          end else begin
            rx_timer <= rx_timer - 1'b1;
          end
        end
        RX_STOP: begin
          // wait out the remainder of the frame before rearming
          if (rx_timer == 16'h0000) begin
            if (rx && locked && bit_cnt != 16'h0000 && rx_bits == 4'h8) begin
              rx_strobe <= 1'b1;
              rx_byte <= rx_shift;
            end
            rx_bits <= 4'h0;
            if (rx) begin
              rx_state <= RX_IDLE;
            end
          end else begin
            rx_timer <= rx_timer - 1'b1;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // record parser
  // ----------------------------------------
  localparam P_WAIT = 3'h0;
  localparam P_FIELD = 3'h1;
  localparam P_EXEC = 3'h2;
  localparam P_PROG = 3'h3;
  localparam P_WAITP = 3'h4;
  localparam P_REPLY = 3'h5;
  reg [2:0] p_state;
  reg hi_nib;
  reg [3:0] nib;
  reg [5:0] byte_idx;
  reg [7:0] csum;
  reg [7:0] rec_len;
  reg [15:0] rec_addr;
  reg [7:0] rec_type;
  reg [4:0] prog_idx;
  reg prog_fail;
  reg [7:0] reply;
  reg reply_req;
  wire [7:0] cur_byte;
  wire is_hex;
  wire [3:0] hex_val;
  wire [7:0] buf_rdata;
  wire buf_we;
  // read address runs one step ahead so the registered read is ready in P_PROG
  wire [4:0] rd_idx = (p_state == P_EXEC) ? 5'h00
                      : ((p_state == P_WAITP) && i_prog_done) ? (prog_idx + 5'h01) : prog_idx;
  assign is_hex = (rx_byte >= 8'h30 && rx_byte <= 8'h39) || (rx_byte >= 8'h41 && rx_byte <= 8'h46)
                  || (rx_byte >= 8'h61 && rx_byte <= 8'h66);
  assign hex_val = (rx_byte <= 8'h39) ? rx_byte[3:0] : (rx_byte[3:0] + 4'h9);
  assign cur_byte = {nib, hex_val};
  assign buf_we = rx_strobe && (p_state == P_FIELD) && is_hex && !hi_nib && (byte_idx >= 6'h04)
                  && (byte_idx < 6'h04 + {1'b0, rec_len[4:0]});

  record_buffer #(.WIDTH(8), .DEPTH(16), .AW(4)) u_buf (
    .i_clk(i_clk),
    .i_we(buf_we),
    .i_waddr(byte_idx[3:0] - 4'h4),
    .i_wdata(cur_byte),
    .i_raddr(rd_idx[3:0]),
    .o_rdata(buf_rdata)
  );

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      p_state <= P_WAIT;
      hi_nib <= 1'b1;
      nib <= 4'h0;
      byte_idx <= 6'h00;
      csum <= 8'h00;
      rec_len <= 8'h00;
      rec_addr <= 16'h0000;
      rec_type <= 8'h00;
      prog_idx <= 5'h00;
      prog_fail <= 1'b0;
      reply <= 8'h00;
      reply_req <= 1'b0;
      o_prog_req <= 1'b0;
      o_prog_addr <= 16'h0000;
      o_prog_data <= 8'h00;
      o_eof_seen <= 1'b0;
    end else begin
      reply_req <= 1'b0;
      case (p_state)
        P_WAIT: begin
          // anything but a colon is ignored
          if (rx_strobe && rx_byte == `CH_COLON) begin
            p_state <= P_FIELD;
            hi_nib <= 1'b1;
            byte_idx <= 6'h00;
            csum <= 8'h00;
          end
        end
        P_FIELD: begin
          if (rx_strobe && rx_byte == `CH_COLON) begin
            hi_nib <= 1'b1;
            byte_idx <= 6'h00;
            csum <= 8'h00;
          end else if (rx_strobe && !is_hex) begin
            p_state <= P_WAIT;
          end else if (rx_strobe && hi_nib) begin
            nib <= hex_val;
            hi_nib <= 1'b0;
          end else if (rx_strobe) begin
            hi_nib <= 1'b1;
            csum <= csum + cur_byte;
            byte_idx <= byte_idx + 1'b1;
            if (byte_idx == 6'h00) begin
              rec_len <= cur_byte;
              if (cur_byte > {3'h0, `REC_MAX_DATA}) begin
                p_state <= P_WAIT;
              end
            end
            if (byte_idx == 6'h01) begin
              rec_addr[15:8] <= cur_byte;
            end
            if (byte_idx == 6'h02) begin
              rec_addr[7:0] <= cur_byte;
            end
            if (byte_idx == 6'h03) begin
              rec_type <= cur_byte;
            end
            // checksum byte is the last one; only then act
            if (byte_idx == 6'h04 + {1'b0, rec_len[4:0]}) begin
              p_state <= P_EXEC;
            end
          end
        end
        P_EXEC: begin
          prog_idx <= 5'h00;
          prog_fail <= 1'b0;
          if (csum != 8'h00) begin
            reply <= `CH_CSUM_ERR;
            p_state <= P_REPLY;
          end else if (rec_type == `REC_DATA && rec_len != 8'h00) begin
            p_state <= P_PROG;
          end else begin
            o_eof_seen <= o_eof_seen | (rec_type == `REC_EOF);
            reply <= `CH_OK;
            p_state <= P_REPLY;
          end
        end
        P_PROG: begin
          // buffer's registered read was issued a cycle earlier; request and data go out now
          o_prog_req <= 1'b1;
          o_prog_addr <= rec_addr + {11'h000, prog_idx};
          o_prog_data <= buf_rdata;
          p_state <= P_WAITP;
        end
        P_WAITP: begin
          o_prog_req <= 1'b0;
          if (i_prog_done) begin
            prog_fail <= prog_fail | !i_prog_ok;
            if ({3'h0, prog_idx} + 8'h01 == rec_len) begin
              reply <= (prog_fail || !i_prog_ok) ? `CH_PROG_ERR : `CH_OK;
              p_state <= P_REPLY;
            end else begin
              prog_idx <= prog_idx + 1'b1;
              p_state <= P_PROG;
            end
          end
        end
        P_REPLY: begin
          reply_req <= 1'b1;
          p_state <= P_WAIT;
        end
        default: p_state <= P_WAIT;
      endcase
    end
  end

  // ----------------------------------------
  // transmit queue and transmitter
  // ----------------------------------------
  // echo and status share the queue; status waits a cycle if echo collides
  reg pend_reply;
  wire fifo_push;
  wire fifo_ready;
  wire [7:0] fifo_in;
  wire tx_valid;
  wire [7:0] tx_data;
  reg tx_busy;
  reg [3:0] tx_bits;
  reg [BW-1:0] tx_timer;
  reg [8:0] tx_shift;
  wire tx_take;
  assign fifo_in = rx_strobe ? rx_byte : reply;
  assign fifo_push = (rx_strobe && locked) || pend_reply;
  assign tx_take = tx_valid && !tx_busy;

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      pend_reply <= 1'b0;
    end else if (reply_req || pend_reply) begin
      pend_reply <= !((!rx_strobe) && fifo_ready && pend_reply) || reply_req;
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(3)) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_valid(fifo_push),
    .o_ready(fifo_ready),
    .i_data(fifo_in),
    .o_valid(tx_valid),
    .i_ready(!tx_busy),
    .o_data(tx_data)
  );

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_txd <= 1'b1;
      tx_busy <= 1'b0;
      tx_bits <= 4'h0;
      tx_timer <= 16'h0000;
      tx_shift <= 9'h1FF;
    end else if (tx_take) begin
      tx_busy <= 1'b1;
      o_txd <= 1'b0;
      tx_shift <= {1'b1, tx_data};
      tx_bits <= 4'h0;
      tx_timer <= bit_cnt - 1'b1;
    end else if (tx_busy) begin
      if (tx_timer == 16'h0000) begin
        tx_timer <= bit_cnt - 1'b1;
        if (tx_bits == 4'h9) begin
          tx_busy <= 1'b0;
        end else begin
          o_txd <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[8:1]};
          tx_bits <= tx_bits + 1'b1;
        end
      end else begin
        tx_timer <= tx_timer - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [test/loader_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module loader_sva #(
  parameter FLASH_32K = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // watched ports
  input wire logic o_txd,
  input wire logic i_external_fetch_select_pin,
  input wire logic [15:0] i_fetch_addr,
  input wire logic o_fetch_internal,
  input wire logic o_fetch_external,
  input wire logic o_fetch_boot,
  input wire logic o_prog_req,
  input wire logic i_prog_done,
  input wire logic o_baud_locked,
  input wire logic o_eof_seen
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  localparam logic [15:0] TOP = FLASH_32K ? 16'h7FFF : 16'h3FFF;
  logic pending;
  always @(posedge i_clk) begin
    if (!i_resetn) pending <= 1'b0;
    else if (o_prog_req) pending <= 1'b1;
    else if (i_prog_done) pending <= 1'b0;
  end
  // pin passes a two-stage sync, so three samples settle it
  sequence pin_hi3; i_external_fetch_select_pin [*3]; endsequence
  sequence pin_lo3; !i_external_fetch_select_pin [*3]; endsequence
  boot_map_a:
    assert property (i_fetch_addr >= 16'hF800 |-> o_fetch_boot && !o_fetch_internal)
    else $error("boot area not steered");
  int_fetch_a:
    assert property (pin_hi3 ##0 i_fetch_addr <= TOP |-> o_fetch_internal && !o_fetch_external)
    else $error("internal fetch not steered");
  ext_above_a:
    assert property (pin_hi3 ##0 (i_fetch_addr > TOP && i_fetch_addr < 16'hF800)
      |-> o_fetch_external && !o_fetch_internal) else $error("fetch above top not external");
  ext_low_a:
    assert property (pin_lo3 ##0 i_fetch_addr < 16'hF800 |-> o_fetch_external && !o_fetch_internal)
    else $error("pin low fetch not external");
  one_route_a:
    assert property ($onehot({o_fetch_internal, o_fetch_external, o_fetch_boot}))
    else $error("fetch route not unique");
  prog_pulse_a:
    assert property ($rose(o_prog_req) |=> !o_prog_req) else $error("program request too long");
  req_wait_a:
    assert property (o_prog_req |-> !pending) else $error("program request before done");
  eof_sticky_a:
    assert property (o_eof_seen |=> o_eof_seen) else $error("end of file flag dropped");
  lock_sticky_a:
    assert property (o_baud_locked |=> o_baud_locked) else $error("baud lock dropped");
  txd_quiet_a:
    assert property (!o_baud_locked |-> o_txd) else $error("serial out active before lock");
endmodule
bind hex_record_loader loader_sva #(.FLASH_32K(FLASH_32K)) u_sva (
  .i_clk(i_clk), .i_resetn(i_resetn), .o_txd(o_txd),
  .i_external_fetch_select_pin(i_external_fetch_select_pin), .i_fetch_addr(i_fetch_addr),
  .o_fetch_internal(o_fetch_internal), .o_fetch_external(o_fetch_external),
  .o_fetch_boot(o_fetch_boot), .o_prog_req(o_prog_req), .i_prog_done(i_prog_done),
  .o_baud_locked(o_baud_locked), .o_eof_seen(o_eof_seen));
`default_nettype wire

// [test/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model #(
  parameter BIT = 8
) (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  // ----------------------------------------
  // 8N1 serial host, lsb first
  // ----------------------------------------
  logic [7:0] rxq[$];
  initial o_rxd = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    int i;
    @(posedge i_clk);
    o_rxd <= 1'b0;
    for (i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_clk);
      o_rxd <= b[i];
    end
    repeat (BIT) @(posedge i_clk);
    o_rxd <= 1'b1;
    repeat (BIT) @(posedge i_clk);
  endtask
  // sample mid bit, as a real host receiver would
  always begin : rx
    logic [7:0] b;
    @(negedge i_txd);
    repeat (BIT / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_clk);
      b[i] = i_txd;
    end
    repeat (BIT) @(posedge i_clk);
    rxq.push_back(b);
  end
endmodule
`default_nettype wire

// [test/serial_hex_record_loader_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hex_loader_consts.vh"
module serial_hex_record_loader_test;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  localparam int BIT = 8;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_rxd;
  logic pin = 1'b1;
  logic [15:0] i_fetch_addr = 16'h0000;
  logic i_prog_done = 1'b0;
  logic i_prog_ok = 1'b1;
  wire o_txd, o_fi, o_fe, o_fb, o_prog_req, o_baud_locked, o_eof_seen;
  wire [15:0] o_prog_addr;
  wire [7:0] o_prog_data;
  int mismatches = 0;
  int n_checks = 0;
  int lat = 0;
  int fail_at = 0;
  logic [15:0] addr_q[$];
  logic [7:0] data_q[$];
  logic [7:0] dat[0:16];
  logic [15:0] a;
  always #50 i_clk = ~i_clk;
  hex_record_loader #(.FLASH_32K(1)) dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_rxd(i_rxd), .o_txd(o_txd), .i_external_fetch_select_pin(pin),
    .i_fetch_addr(i_fetch_addr), .o_fetch_internal(o_fi), .o_fetch_external(o_fe),
    .o_fetch_boot(o_fb), .o_prog_req(o_prog_req), .o_prog_addr(o_prog_addr),
    .o_prog_data(o_prog_data), .i_prog_done(i_prog_done), .i_prog_ok(i_prog_ok),
    .o_baud_locked(o_baud_locked), .o_eof_seen(o_eof_seen));
  host_model #(.BIT(BIT)) u_host (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd));
  // flash with random latency; one chosen byte can be made to fail
  always @(posedge i_clk) begin
    i_prog_done <= 1'b0;
    if (o_prog_req) begin
      addr_q.push_back(o_prog_addr);
      data_q.push_back(o_prog_data);
      lat <= 1 + $urandom % 4;
    end else if (lat == 1) begin
      i_prog_done <= 1'b1;
      i_prog_ok <= (fail_at != addr_q.size());
      lat <= 0;
    end else if (lat > 1) lat <= lat - 1;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    hx = (v < 10) ? 8'h30 + v : 8'h37 + v;
  endfunction
  function automatic logic [2:0] route(input logic p, input logic [15:0] ad);
    route = (ad >= 16'hF800) ? 3'b001 : (p && ad <= 16'h7FFF) ? 3'b100 : 3'b010;
  endfunction
  task automatic fetch(input logic p, input logic [15:0] ad);
    @(posedge i_clk);
    pin <= p;
    i_fetch_addr <= ad;
    repeat (3) @(posedge i_clk);
    #1 check("fetch route", route(p, ad), {o_fi, o_fe, o_fb});
  endtask
  // csum_off nonzero spoils the checksum; status 0 means no answer expected
  task automatic send_rec(input logic [7:0] typ, input logic [15:0] ad, input int n,
                          input logic [7:0] csum_off, input logic [7:0] status);
    logic [7:0] b[$];
    logic [7:0] s[$];
    logic [7:0] sum;
    int k;
    b = '{n[7:0], ad[15:8], ad[7:0], typ};
    for (k = 0; k < n; k++) b.push_back(dat[k]);
    sum = 8'h00;
    foreach (b[j]) sum += b[j];
    b.push_back(8'h00 - sum + csum_off);
    s.push_back(`CH_COLON);
    foreach (b[j]) begin
      s.push_back(hx(b[j][7:4]));
      s.push_back(hx(b[j][3:0]));
    end
    addr_q.delete();
    data_q.delete();
    u_host.rxq.delete();
    foreach (s[j]) u_host.send_byte(s[j]);
    if (status != 8'h00) s.push_back(status);
    k = 0;
    while (u_host.rxq.size() < s.size() && k < 2000) begin
      @(posedge i_clk);
      k++;
    end
    repeat (30 * BIT) @(posedge i_clk);
    check("echo count", s.size(), u_host.rxq.size());
    foreach (s[j]) if (j < u_host.rxq.size()) check("echo char", s[j], u_host.rxq[j]);
    if (status == `CH_OK && typ == `REC_DATA) begin
      check("prog count", n, addr_q.size());
      foreach (addr_q[j]) check("prog addr", ad + j, addr_q[j]);
      foreach (data_q[j]) check("prog data", dat[j], data_q[j]);
    end else if (status != `CH_PROG_ERR) check("no prog", 0, addr_q.size());
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h014F));
    repeat (20) @(posedge i_clk);
    #1 check("txd idle", 1, o_txd);
    check("lock reset", 0, o_baud_locked);
    check("eof reset", 0, o_eof_seen);
    @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    u_host.send_byte(`CH_SYNC);
    repeat (25 * BIT) @(posedge i_clk);
    check("baud lock", 1, o_baud_locked);
    foreach (dat[j]) dat[j] = $urandom;
    foreach (dat[j]) begin
      fetch(1'b1, {1'b0, dat[j], 7'h7F});
      // last flash byte is only fetched, never loaded, as software is expected to do
      fetch(j[0], 16'h7FFF + j[0]);
      fetch(j[0], 16'hF7FF + j[0]);
      fetch(1'b0, $urandom);
    end
    a = $urandom % 16'h7F00;
    send_rec(`REC_DATA, a, 16, 8'h00, `CH_OK);
    send_rec(`REC_DATA, a, 4, 8'h01, `CH_CSUM_ERR);
    fail_at = 3;
    send_rec(`REC_DATA, a + 16'h0020, 5, 8'h00, `CH_PROG_ERR);
    fail_at = 0;
    send_rec(`REC_OSC, $urandom, 1, 8'h00, `CH_OK);
    send_rec(`REC_DATA, a, 17, 8'h00, 8'h00);
    send_rec(`REC_DATA, 16'h0000, 0, 8'h00, `CH_OK);
    send_rec(`REC_EOF, $urandom, 0, 8'h80, `CH_CSUM_ERR);
    check("eof after bad", 0, o_eof_seen);
    send_rec(`REC_EOF, $urandom, 0, 8'h00, `CH_OK);
    check("eof seen", 1, o_eof_seen);
    print_verdict();
  end
endmodule
`default_nettype wire
